// [rtl/gcr_device.sv]
// Overview of operation
// - Pin low: pins defined, no refreshes
// - Chip select sampled cycle before release
// - Host-present: halt, refresh, await halt clear
// - Host waits for eight init cycles
// - Bootstrap: eight refreshes, then vector fetch
// - Vector low nibble loads configuration
// - Reset, trap zero, saved-mode NMI skip push
// - Power up: reset low 40 clocks
// - Four-clock reset accepted; 34-clock internal reset
// - Reset release retimed by shared clock
// - Release aligns quarter phase to first
// - Row strobe high while pin low
// - Eight CBR refreshes before memory grant
// - Host holds off until init done
// - Refresh every eight clocks after reset
// - Reset pin pattern high, low, floating
// - Isolate floats all controlled pins
// - I/O registers clear; halt from select
// - Status word 0000_0010 before first instruction
// - PC takes vector upper 28 bits
// - Config bits from vector; protect lower byte
// - Cache present flags clear, LRU 0..3
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
module gcr_device (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  gcr_link_if.dev          link,
  input  wire logic        exc_req_i,         // Pulse: interrupt or trap entry
  input  wire logic        exc_trap0_i,       // Entry is trap zero
  input  wire logic        cfg_we_i,          // Software config write
  input  wire logic [15:0] cfg_wdata_i,
  input  wire logic        ref_period_we_i,   // Software refresh period write
  input  wire logic [7:0]  ref_period_i,
  output logic [2:0]       state_o,
  output logic             halt_flag_o,
  output logic [15:0]      config_o,
  output logic [31:0]      pc_o,
  output logic [31:0]      status_word_o,
  output logic [1:0]       quarter_o,
  output logic [3:0]       present_flags_o,
  output logic [7:0]       lru_order_o,
  output logic             push_o             // Pulse: state pushed on entry
);
  import gcr_pkg::*;
  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  gcr_state_e  state_r;                       // Sequencer state
  logic        pin_q_r;                       // Pin level last cycle
  logic        hcs_q_r;                       // Chip select last cycle
  logic [2:0]  lowcnt_r;                      // Consecutive low clocks
  logic [5:0]  cnt_r;                         // Internal reset counter
  logic [3:0]  refs_r;                        // Init refreshes done
  logic [7:0]  ref_tmr_r;                     // Refresh interval timer
  logic [1:0]  ref_ph_r;                      // CBR phase, 0 = idle
  logic        pin_low;
  logic        rise;
  logic        ref_ok;
  logic        ref_done;
  logic [7:0]  ref_period_r;

  assign pin_low  = !link.reset_n;
  assign rise     = link.reset_n && !pin_q_r;
  assign ref_ok   = !pin_low && (state_r != ST_RESET);
  assign ref_done = (ref_ph_r == 2'd2);

  // ----------------------------------------------------------------
  // Pin and strap history
  // ----------------------------------------------------------------
  // The strap is the level one clock before the rising edge
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_q_r  <= 1'b0;
      hcs_q_r  <= 1'b1;
      lowcnt_r <= 3'd0;
    end else begin
      pin_q_r  <= link.reset_n;
      hcs_q_r  <= link.host_chip_select_n;
      if (!pin_low) begin
        lowcnt_r <= 3'd0;
      end else if (lowcnt_r != 3'(RESET_LOW_CLKS)) begin
        lowcnt_r <= lowcnt_r + 3'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Short glitches never enter reset; the fourth low clock does, so the
  // release right after a four-clock pulse is still seen as a rise
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= ST_RESET;
      cnt_r   <= 6'd0;
      refs_r  <= 4'd0;
    end else if (pin_low && lowcnt_r >= 3'(RESET_LOW_CLKS - 1)) begin
      state_r <= ST_RESET;
    end else begin
      unique case (state_r)
        ST_RESET: begin
          cnt_r  <= 6'd0;
          refs_r <= 4'd0;
          if (rise) begin
            state_r <= ST_INTRST;
          end
        end
        ST_INTRST: begin
          // Refreshes run here but do not count towards init
          cnt_r <= cnt_r + 6'd1;
          if (cnt_r == 6'(INT_RESET_CLKS - 1)) begin
            state_r <= ST_INITREF;
          end
        end
        ST_INITREF: begin
          if (ref_done) begin
            refs_r <= refs_r + 4'd1;
            if (refs_r == 4'(INIT_REFRESHES - 1)) begin
              state_r <= halt_flag_o ? ST_HALT : ST_FETCH;
            end
          end
        end
        ST_HALT: begin
          if (!halt_flag_o) begin
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (link.vec_valid) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_r <= ST_RUN;
        end
        default: begin
          state_r <= ST_RESET;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Refresh scheduler
  // ----------------------------------------------------------------
  // CBR cycle: column strobes fall first, row strobe joins next clock
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_tmr_r <= 8'h00;
      ref_ph_r  <= 2'd0;
    end else if (!ref_ok) begin
      ref_tmr_r <= 8'h00;
      ref_ph_r  <= 2'd0;
    end else begin
      if (ref_ph_r != 2'd0) begin
        ref_ph_r <= (ref_ph_r == 2'd2) ? 2'd0 : ref_ph_r + 2'd1;
      end
      if (ref_tmr_r == ref_period_r - 8'h01) begin
        ref_tmr_r <= 8'h00;
        ref_ph_r  <= 2'd1;
      end else begin
        ref_tmr_r <= ref_tmr_r + 8'h01;
      end
    end
  end

  // Period restarts at eight on every reset; a zero write is ignored
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_period_r <= REFRESH_PERIOD_RST;
    end else if (state_r == ST_RESET) begin
      ref_period_r <= REFRESH_PERIOD_RST;
    end else if (ref_period_we_i && ref_period_i != 8'h00) begin
      ref_period_r <= ref_period_i;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      halt_flag_o     <= 1'b1;
      config_o        <= IOREG_RST;
      pc_o            <= 32'h00000000;
      status_word_o   <= STATUS_RST;
      present_flags_o <= 4'h0;
      lru_order_o     <= LRU_RST;
    end else if (state_r == ST_RESET) begin
      config_o        <= IOREG_RST;
      status_word_o   <= STATUS_RST;
      present_flags_o <= 4'h0;
      lru_order_o     <= LRU_RST;
      if (rise) begin
        halt_flag_o <= hcs_q_r;
      end
    end else begin
      if (link.halt_clear) begin
        halt_flag_o <= 1'b0;
      end
      if (state_r == ST_FETCH && link.vec_valid) begin
        pc_o     <= {link.vec_data[31:4], 4'h0};
        config_o <= {config_o[15:4], link.vec_data[3:0]};
      end else if (cfg_we_i) begin
        config_o[15:8] <= cfg_wdata_i[15:8];
        if (!config_o[CFG_PROTECT_BIT]) begin
          config_o[7:0] <= cfg_wdata_i[7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Quarter phase and entry push
  // ----------------------------------------------------------------
  // Peers sharing the retimed release land on the same quarter
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      quarter_o <= 2'd0;
      push_o    <= 1'b0;
    end else begin
      quarter_o <= rise ? 2'd0 : quarter_o + 2'd1;
      // Stack pointer may be junk at these entries, so no push
      push_o    <= state_r == ST_RUN && ((exc_req_i && !exc_trap0_i) ||
                   (link.nmi && !link.nmi_state_save_mode));
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  logic in_rst;
  assign in_rst = pin_low || state_r == ST_RESET || state_r == ST_INTRST;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {link.row_strobe_n, link.col_strobe_n} <= {1'b1, STROBE_IDLE};
      {link.host_ready, link.mem_gnt, link.vec_req, link.pins_oe,
       link.local_addr_data_bus_oe}         <= 5'h00;
      link.local_addr_data_bus_o             <= 32'h00000000;
    end else begin
      // Row strobe low only in CBR phase one, never while pin low
      link.row_strobe_n <= !(ref_ok && ref_ph_r == 2'd1);
      link.col_strobe_n <= (ref_ok && ref_ph_r != 2'd0 && ref_ph_r != 2'd2) ||
                           (ref_ok && ref_tmr_r == ref_period_r - 8'h01) ?
                           4'h0 : STROBE_IDLE;
      link.host_ready   <= !in_rst;
      link.mem_gnt      <= link.mem_req && !pin_low && ref_ph_r == 2'd0 &&
                           (state_r == ST_HALT || state_r == ST_FETCH ||
                            state_r == ST_RUN);
      link.vec_req      <= !pin_low && state_r == ST_FETCH && !link.vec_valid;
      link.pins_oe      <= !link.global_isolate;
      link.local_addr_data_bus_oe <= !link.global_isolate && !pin_low &&
                                     state_r == ST_FETCH;
      link.local_addr_data_bus_o  <= VECTOR_ADDR;
    end
  end

  // Reset pattern levels; all but data_dir_in are shared with normal operation,
  // loaded by the reset and then held, as only data_dir_in and state_o ever change
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {link.write_en_n, link.transfer_output_enable, link.data_dir_out,
       link.address_latch_strobe, link.host_interrupt_out, link.bus_request_zero,
       link.bus_request_one, link.host_output_enable, link.host_data_strobe,
       link.emulation_pin_3, link.special_function_pin} <= 11'h7FF;
      link.row_col_address_bus <= RCA_IDLE;
      {link.blank_output, link.data_dir_in, link.sync_oe, link.sync_o} <= 6'h00;
      state_o                  <= ST_RESET;
    end else begin
      link.data_dir_in <= !in_rst;
      state_o          <= state_r;
    end
  end
endmodule : gcr_device

// [rtl/gcr_pkg.sv]
package gcr_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_PS      = 5000;    // 200 MHz local clock
  localparam int          PWRUP_LOW_CLKS     = 40;      // Least low time at power up
  localparam int          RESET_LOW_CLKS     = 4;       // Least low time otherwise
  localparam int          INT_RESET_CLKS     = 34;      // Internal reset state length
  localparam int          INIT_REFRESHES     = 8;       // CBR cycles before any access
  localparam logic [7:0]  REFRESH_PERIOD_RST = 8'h08;   // One refresh per 8 clocks
  localparam int          ALIGN_QUARTERS     = 10;      // Peers aligned within this
  // Host hold-off: internal reset plus all init refreshes, with slack
  localparam int          HOST_HOLDOFF_CLKS  =
    INT_RESET_CLKS + INIT_REFRESHES * 8 + 8;
  // ----------------------------------------------------------------
  // Reset values and vector layout
  // ----------------------------------------------------------------
  localparam logic [31:0] VECTOR_ADDR        = 32'hFFFFFFE0; // Level-0 vector
  localparam logic [31:0] STATUS_RST         = 32'h00000010;
  localparam logic [15:0] IOREG_RST          = 16'h0000;
  localparam int          CFG_ENDIAN_BIT     = 0;
  localparam int          CFG_PROTECT_BIT    = 1;
  localparam int          CFG_ROW_COL_MODE_0_BIT       = 2;
  localparam int          CFG_ROW_COL_MODE_1_BIT       = 3;
  localparam logic [7:0]  LRU_RST            = 8'hE4;   // {3,2,1,0}: entry 0 is MRU
  localparam logic [3:0]  STROBE_IDLE        = 4'hF;
  localparam logic [12:0] RCA_IDLE           = 13'h1FFF;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RESET   = 3'b000,  // Pin low or power-up
    ST_INTRST  = 3'b001,  // Internal reset state after release
    ST_INITREF = 3'b010,  // Automatic DRAM init refreshes
    ST_HALT    = 3'b011,  // Host-present, waiting for halt clear
    ST_FETCH   = 3'b100,  // Reset vector fetch
    ST_RUN     = 3'b101   // Executing
  } gcr_state_e;
endpackage : gcr_pkg

// [rtl/gcr_link_if.sv]
`timescale 1ns/100ps
interface gcr_link_if;
  // Host to device
  logic        reset_n;            // Reset pin, retimed by the clock
  logic        host_chip_select_n; // Start mode strap at release
  logic        halt_clear;         // Pulse: host clears halt_flag
  logic        nmi;                // Pulse: host nonmaskable interrupt
  logic        nmi_state_save_mode;
  logic        global_isolate;
  logic        mem_req;            // Host memory request level
  logic        vec_valid;          // Pulse: vector word returned
  logic [31:0] vec_data;
  // Device to host
  logic        mem_gnt;
  logic        vec_req;            // Level until vec_valid
  logic        row_strobe_n;
  logic [3:0]  col_strobe_n;
  logic        write_en_n;
  logic        transfer_output_enable;
  logic        data_dir_out;
  logic        data_dir_in;
  logic        address_latch_strobe;
  logic        host_interrupt_out;
  logic        bus_request_zero;
  logic        bus_request_one;
  logic        host_output_enable;
  logic        host_data_strobe;
  logic        emulation_pin_3;
  logic [12:0] row_col_address_bus;
  logic        special_function_pin;
  logic        host_ready;
  logic        blank_output;
  logic        pins_oe;            // Enable of all isolate-controlled pins
  logic [2:0]  sync_o;
  logic        sync_oe;
  logic [31:0] local_addr_data_bus_o;
  logic        local_addr_data_bus_oe;

  modport dev (
    input  reset_n, host_chip_select_n, halt_clear, nmi, nmi_state_save_mode,
    input  global_isolate, mem_req, vec_valid, vec_data,
    output mem_gnt, vec_req, row_strobe_n, col_strobe_n, write_en_n,
    output transfer_output_enable, data_dir_out, data_dir_in, address_latch_strobe,
    output host_interrupt_out, bus_request_zero, bus_request_one, host_output_enable,
    output host_data_strobe, emulation_pin_3, row_col_address_bus,
    output special_function_pin, host_ready, blank_output, pins_oe, sync_o, sync_oe,
    output local_addr_data_bus_o, local_addr_data_bus_oe
  );
  modport host (
    output reset_n, host_chip_select_n, halt_clear, nmi, nmi_state_save_mode,
    output global_isolate, mem_req, vec_valid, vec_data,
    input  mem_gnt, vec_req, row_strobe_n, col_strobe_n, local_addr_data_bus_o,
    input  local_addr_data_bus_oe
  );
endinterface : gcr_link_if

// [rtl/gcr_host.sv]
`timescale 1ns/100ps
module gcr_host (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  gcr_link_if.host         link,
  input  wire logic        rst_req_i,         // Pulse: request a device reset
  input  wire logic        host_present_i,    // Start halted when high
  input  wire logic        halt_clear_i,      // Pulse: release halted device
  input  wire logic        nmi_i,
  input  wire logic        nmi_save_mode_i,
  input  wire logic        isolate_i,
  input  wire logic        mem_req_i,
  input  wire logic [31:0] vector_i,          // Word at the reset vector
  output logic             mem_gnt_o,
  output logic             ready_o            // Hold-off over, device usable
);
  import gcr_pkg::*;

  // ----------------------------------------------------------------
  // Reset driver
  // ----------------------------------------------------------------
  logic [5:0] low_r;                          // Clocks left low
  logic [7:0] hold_r;                         // Clocks left of hold-off
  logic       first_r;                        // Power-up reset pending

  // Release is a clocked edge, so peers on this clock align
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link.reset_n <= 1'b0;
      low_r        <= 6'(PWRUP_LOW_CLKS);
      first_r      <= 1'b1;
      hold_r       <= 8'(HOST_HOLDOFF_CLKS);
    end else if (rst_req_i && !first_r) begin
      link.reset_n <= 1'b0;
      low_r        <= 6'(RESET_LOW_CLKS);
      hold_r       <= 8'(HOST_HOLDOFF_CLKS);
    end else if (low_r != 6'd0) begin
      low_r        <= low_r - 6'd1;
      link.reset_n <= (low_r == 6'd1);
    end else begin
      first_r      <= 1'b0;
      if (hold_r != 8'd0) begin
        hold_r <= hold_r - 8'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control levels, requests and vector memory
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link.host_chip_select_n  <= 1'b1;
      link.halt_clear          <= 1'b0;
      link.nmi                 <= 1'b0;
      link.nmi_state_save_mode <= 1'b0;
      link.global_isolate      <= 1'b0;
      link.mem_req             <= 1'b0;
      link.vec_valid           <= 1'b0;
      link.vec_data            <= 32'h00000000;
      mem_gnt_o                <= 1'b0;
      ready_o                  <= 1'b0;
    end else begin
      // A high strap at release asks the device for a halted start
      link.host_chip_select_n  <= host_present_i;
      link.halt_clear          <= halt_clear_i && hold_r == 8'd0;
      link.nmi                 <= nmi_i;
      link.nmi_state_save_mode <= nmi_save_mode_i;
      link.global_isolate      <= isolate_i;
      // No requests until the init refreshes have surely finished
      link.mem_req             <= mem_req_i && hold_r == 8'd0 &&
                                  link.reset_n;
      link.vec_valid           <= link.vec_req && !link.vec_valid;
      link.vec_data            <= vector_i;
      mem_gnt_o                <= link.mem_gnt;
      ready_o                  <= hold_r == 8'd0 && link.reset_n;
    end
  end
endmodule : gcr_host

// [dv/gcr_assertions.sv]
`timescale 1ns/100ps
module gcr_assertions
  import gcr_pkg::*;
(
  input wire logic        mclk_i, rstn_i, reset_n, host_chip_select_n, halt_clear,
  input wire logic        global_isolate, mem_gnt, vec_req, row_strobe_n,
  input wire logic [3:0]  col_strobe_n,
  input wire logic        host_ready, pins_oe, sync_oe, local_addr_data_bus_oe,
  input wire logic [12:0] row_col_address_bus,
  input wire logic [31:0] local_addr_data_bus_o
);
  logic [8:0] since_r;                 // Clocks since pin release
  logic [3:0] nref_r;                  // Refreshes since pin release
  logic       rn_r, hcs_r, strap_r, clr_r;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // Release bookkeeping; a pin reset restarts it
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {since_r, nref_r, rn_r, hcs_r, strap_r, clr_r} <= '0;
    end else begin
      {rn_r, hcs_r} <= {reset_n, host_chip_select_n};
      if (reset_n && !rn_r) strap_r <= hcs_r;
      if (!reset_n) begin
        {since_r, nref_r, clr_r} <= '0;
      end else begin
        if (since_r != 9'h1FF) since_r <= since_r + 9'd1;
        if ($fell(col_strobe_n[0]) && row_strobe_n && nref_r != 4'hF) nref_r <= nref_r + 4'd1;
        clr_r <= clr_r | halt_clear;
      end
    end
  end
  // Registered pins: judged from the second low cycle on
  sequence s_low; !reset_n && !$past(reset_n); endsequence
  sequence s_cbr; !col_strobe_n[0] && row_strobe_n ##1 !col_strobe_n[0] && !row_strobe_n; endsequence
  property p_ras; s_low |-> row_strobe_n; endproperty
  a_ras: assert property (p_ras) else $error("row strobe active in reset");
  property p_noref; s_low |-> col_strobe_n == STROBE_IDLE; endproperty
  a_noref: assert property (p_noref) else $error("refresh in reset");
  property p_pins;
    s_low |-> !host_ready && !sync_oe && !local_addr_data_bus_oe && row_col_address_bus == RCA_IDLE;
  endproperty
  a_pins: assert property (p_pins) else $error("reset pin pattern wrong");
  property p_iso; global_isolate && $past(global_isolate) |-> !pins_oe; endproperty
  a_iso: assert property (p_iso) else $error("pins driven while isolated");
  property p_lad;
    local_addr_data_bus_oe |-> local_addr_data_bus_o == VECTOR_ADDR && (vec_req || $past(vec_req));
  endproperty
  a_lad: assert property (p_lad) else $error("vector address wrong");
  property p_init; mem_gnt || vec_req |-> since_r >= 9'd92 && nref_r >= 4'd8; endproperty
  a_init: assert property (p_init) else $error("access before init refreshes");
  property p_gap;
    disable iff (!rstn_i || !reset_n)
      $fell(col_strobe_n[0]) && row_strobe_n |-> s_cbr ##1 col_strobe_n[0] [*6];
  endproperty
  a_gap: assert property (p_gap) else $error("refresh spacing short");
  property p_halt; $rose(vec_req) |-> !strap_r || clr_r; endproperty
  a_halt: assert property (p_halt) else $error("fetch while halted");
  property p_boot; $rose(reset_n) && !$past(host_chip_select_n) |-> ##[92:200] vec_req; endproperty
  a_boot: assert property (p_boot) else $error("no bootstrap fetch");
endmodule : gcr_assertions

// [dv/testbench.sv]
`timescale 1ns/100ps
module testbench;
  import gcr_pkg::*;
  logic        mclk_i, rstn_i, rst_req_i, host_present_i, halt_clear_i, nmi_i;
  logic        nmi_save_mode_i, isolate_i, mem_req_i, exc_req_i, exc_trap0_i;
  logic        cfg_we_i, ref_period_we_i, mem_gnt_o, ready_o, halt_flag_o, push_o;
  logic [15:0] cfg_wdata_i, config_o;
  logic [31:0] vector_i, pc_o, status_word_o;
  logic [7:0]  ref_period_i, lru_order_o;
  logic [3:0]  present_flags_o;
  logic [1:0]  quarter_o;
  logic [2:0]  state_o;
  int          fails, cmp_count, i;
  gcr_link_if link ();
  gcr_host u_gcr_host (.mclk_i, .rstn_i, .link(link), .rst_req_i, .host_present_i,
    .halt_clear_i, .nmi_i, .nmi_save_mode_i, .isolate_i, .mem_req_i, .vector_i,
    .mem_gnt_o, .ready_o);
  gcr_device u_gcr_device (.mclk_i, .rstn_i, .link(link), .exc_req_i, .exc_trap0_i,
    .cfg_we_i, .cfg_wdata_i, .ref_period_we_i, .ref_period_i, .state_o, .halt_flag_o,
    .config_o, .pc_o, .status_word_o, .quarter_o, .present_flags_o, .lru_order_o, .push_o);
  gcr_assertions u_gcr_assertions (.mclk_i, .rstn_i, .reset_n(link.reset_n),
    .host_chip_select_n(link.host_chip_select_n), .halt_clear(link.halt_clear),
    .global_isolate(link.global_isolate), .mem_gnt(link.mem_gnt), .vec_req(link.vec_req),
    .row_strobe_n(link.row_strobe_n), .col_strobe_n(link.col_strobe_n),
    .host_ready(link.host_ready), .pins_oe(link.pins_oe), .sync_oe(link.sync_oe),
    .local_addr_data_bus_oe(link.local_addr_data_bus_oe),
    .row_col_address_bus(link.row_col_address_bus),
    .local_addr_data_bus_o(link.local_addr_data_bus_o));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // Bounded wait for a sequencer state
  task automatic wait_st(input gcr_state_e s);
    for (i = 0; i < 400 && state_o !== s; i++) @(posedge mclk_i);
    chk("state", 32'(state_o), 32'(s));
  endtask : wait_st
  task automatic cfg_wr(input logic [15:0] d, input logic [15:0] exp);
    @(posedge mclk_i);
    cfg_wdata_i <= d;
    cfg_we_i    <= 1'b1;
    @(posedge mclk_i);
    cfg_we_i    <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk("config", 32'(config_o), 32'(exp));
  endtask : cfg_wr
  // Trap or host interrupt entry; push watched for five clocks
  task automatic entry(input bit nm, input logic arg, input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge mclk_i);
    if (nm) {nmi_save_mode_i, nmi_i} <= {arg, 1'b1};
    else {exc_trap0_i, exc_req_i} <= {arg, 1'b1};
    @(posedge mclk_i);
    {nmi_i, exc_req_i} <= 2'b00;
    repeat (5) @(posedge mclk_i) seen = seen | push_o;
    chk("push", 32'(seen), 32'(exp));
  endtask : entry
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  // Watchdog, far beyond the expected run
  initial begin
    #10000;
    fails++;
    stop_test();
  end
  initial begin
    {rstn_i, rst_req_i, host_present_i, halt_clear_i, nmi_i, nmi_save_mode_i} = '0;
    {isolate_i, mem_req_i, exc_req_i, exc_trap0_i, cfg_we_i, ref_period_we_i} = '0;
    {cfg_wdata_i, ref_period_i} = '0;
    vector_i = 32'h1234567B;
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    wait_st(ST_RUN);
    chk("pc", pc_o, 32'h12345670);
    chk("config", 32'(config_o), 32'h0000000B);
    chk("status", status_word_o, 32'h00000010);
    chk("halt", 32'(halt_flag_o), 32'h0);
    chk("cache", {20'h0, present_flags_o, lru_order_o}, 32'h000000E4);
    cfg_wr(16'hA5A5, 16'hA50B);
    entry(1'b0, 1'b1, 1'b0);
    entry(1'b0, 1'b0, 1'b1);
    entry(1'b1, 1'b1, 1'b0);
    entry(1'b1, 1'b0, 1'b1);
    chk("ready", 32'(ready_o), 32'h1);
    mem_req_i <= 1'b1;
    for (i = 0; i < 20 && mem_gnt_o !== 1'b1; i++) @(posedge mclk_i);
    chk("grant", 32'(mem_gnt_o), 32'h1);
    // A stretched refresh period must not survive the next reset
    {mem_req_i, isolate_i, ref_period_we_i} <= 3'b011;
    ref_period_i <= 8'h10;
    repeat (4) @(posedge mclk_i);
    chk("pins_oe", 32'(link.pins_oe), 32'h0);
    {isolate_i, host_present_i, rst_req_i, ref_period_we_i} <= 4'b0110;
    vector_i <= 32'h00001005;
    @(posedge mclk_i);
    rst_req_i <= 1'b0;
    wait_st(ST_INTRST);
    chk("quarter", 32'(quarter_o), 32'h1);
    for (i = 0; i < 100 && state_o === ST_INTRST; i++) @(posedge mclk_i);
    chk("intrst", i, 34);
    wait_st(ST_HALT);
    chk("halt", 32'(halt_flag_o), 32'h1);
    chk("config", 32'(config_o), 32'h0);
    for (i = 0; i < 40 && link.col_strobe_n[0] !== 1'b0; i++) @(posedge mclk_i);
    for (i = 0; i < 40 && link.col_strobe_n[0] !== 1'b1; i++) @(posedge mclk_i);
    for (i = 0; i < 40 && link.col_strobe_n[0] !== 1'b0; i++) @(posedge mclk_i);
    chk("refresh_gap", i, 6);
    repeat (40) @(posedge mclk_i);
    chk("state", 32'(state_o), 32'(ST_HALT));
    halt_clear_i <= 1'b1;
    @(posedge mclk_i);
    halt_clear_i <= 1'b0;
    wait_st(ST_RUN);
    chk("pc", pc_o, 32'h00001000);
    chk("config", 32'(config_o), 32'h00000005);
    cfg_wr(16'h00A0, 16'h00A0);
    stop_test();
  end
endmodule : testbench
